// >>> core/mirror_light_control_pins.sv
// Functional notes
// - light select 00 none,01 red,10 green,11 blue
// - light selects low while reset held
// - no light until initialisation finished
// - one pin: mirror enable high, reset low
// - mirror enable drops only after parking
// - notify line shows init busy, then done
// - notify line released during reset
// - park request low parks mirror, no power-off
// - flash selects active low, spare unused
// - i2c slave on control port takes commands
// - slow mirror link: clock, write, read
// - fast lane order set by configuration
// - thermistor measured by successive approximation
// - thermistor power on while a measurement runs with sensing enabled
// - focus motor sense read as input
// - unused gpio driven as low outputs
// - start configuration on reset release, outputs idle
`include "mirror_light_cfg.svh"
module mirror_light_control_pins (
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  input  wire logic                             init_done,
  input  wire mirror_light_pkg::light_source_t  light_req,
  input  wire logic                             host_projection_on,
  output logic                                  light_select_bit0,
  output logic                                  light_select_bit1,
  output logic                                  mirror_enable_reset_n,
  output logic                                  mirror_parked,
  output logic                                  host_notify_out,
  output logic                                  host_notify_oe,
  input  wire logic                             flash_req,
  output logic                                  flash_select_n,
  output logic                                  spare_flash_select_n,
  input  wire logic                             control_port_clock_line,
  input  wire logic                             control_port_data_line,
  output logic                                  control_port_clock_out,
  output logic                                  control_port_clock_oe,
  output logic                                  control_port_data_out,
  output logic                                  control_port_data_oe,
  output mirror_light_pkg::ctrl_cmd_t           ctrl_cmd,
  input  wire logic                             ls_go,
  input  wire logic [7:0]                       ls_wbyte,
  output logic                                  mirror_slow_serial_clk,
  output logic                                  mirror_slow_write_line,
  input  wire logic                             mirror_slow_read_line,
  output logic [7:0]                            ls_rbyte,
  output logic                                  ls_busy,
  input  wire logic [7:0]                       lane_data,
  input  wire logic [23:0]                      lane_map,
  output logic [7:0]                            mirror_fast_lanes,
  output logic                                  mirror_fast_clk_pos,
  input  wire logic                             therm_enable,
  input  wire logic                             therm_go,
  output logic                                  thermistor_charge_drive,
  output logic                                  thermistor_power,
  input  wire logic                             comparator_result_in,
  output logic [7:0]                            therm_result,
  output logic                                  therm_busy,
  input  wire logic                             focus_motor_sense,
  output logic                                  focus_motor_level,
  output logic                                  focus_motor_oe,
  output logic [15:0]                           spare_gpio_out,
  output logic [15:0]                           spare_gpio_oe
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  mirror_light_pkg::pin_in_t s1_ff, s2_ff, s3_ff, filt_ff;
  mirror_light_pkg::pin_in_t raw;
  assign raw = '{host_projection_on, mirror_slow_read_line, comparator_result_in,
                 focus_motor_sense, control_port_clock_line, control_port_data_line};

  // per bit: a new level counts once stages two and three agree, so a busy pin never stalls the others
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff   <= 6'h3f;
      s2_ff   <= 6'h3f;
      s3_ff   <= 6'h3f;
      filt_ff <= 6'h3f;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
    end
  end

  // ---------------------------------------------------------------
  // sequence control
  // ---------------------------------------------------------------
  localparam int unsigned PARK_LAST = `PARK_CYCLES - 1;
  mirror_light_pkg::ctrl_state_t state_ff, nxt_state;
  logic [11:0] park_cnt_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      mirror_light_pkg::st_reset:   nxt_state = mirror_light_pkg::st_init;
      mirror_light_pkg::st_init:    if (init_done) nxt_state = mirror_light_pkg::st_run;
      mirror_light_pkg::st_run:     if (!filt_ff.park_n) nxt_state = mirror_light_pkg::st_parking;
      mirror_light_pkg::st_parking: if (park_cnt_ff == 12'(PARK_LAST)) nxt_state = mirror_light_pkg::st_parked;
      mirror_light_pkg::st_parked:  if (filt_ff.park_n) nxt_state = mirror_light_pkg::st_run;
      default:                      nxt_state = mirror_light_pkg::st_reset;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) state_ff <= mirror_light_pkg::st_reset;
    else state_ff <= nxt_state;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) park_cnt_ff <= 12'h000;
    else if (state_ff == mirror_light_pkg::st_parking) park_cnt_ff <= park_cnt_ff + 12'h001;
    else park_cnt_ff <= 12'h000;
  end

  // mirror power removal is left to the external supply
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mirror_enable_reset_n <= 1'b0;
      mirror_parked         <= 1'b0;
    end else begin
      mirror_enable_reset_n <= (state_ff == mirror_light_pkg::st_run) ||
                               (state_ff == mirror_light_pkg::st_parking);
      mirror_parked <= (state_ff == mirror_light_pkg::st_parked);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      light_select_bit0 <= 1'b0;
      light_select_bit1 <= 1'b0;
    end else if (state_ff == mirror_light_pkg::st_run && filt_ff.park_n) begin
      light_select_bit0 <= light_req[0];
      light_select_bit1 <= light_req[1];
    end else begin
      light_select_bit0 <= 1'b0;
      light_select_bit1 <= 1'b0;
    end
  end

  // pull-up holds the line high until the busy level is driven
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_notify_oe  <= 1'b0;
      host_notify_out <= `NOTIFY_DONE;
    end else begin
      host_notify_oe  <= 1'b1;
      host_notify_out <= (state_ff == mirror_light_pkg::st_init ||
                          state_ff == mirror_light_pkg::st_reset) ? `NOTIFY_BUSY : `NOTIFY_DONE;
    end
  end

  // ---------------------------------------------------------------
  // flash selects and gpio
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_select_n       <= 1'b1;
      spare_flash_select_n <= 1'b1;
      focus_motor_level    <= 1'b0;
    end else begin
      flash_select_n       <= !(flash_req && state_ff != mirror_light_pkg::st_reset);
      spare_flash_select_n <= 1'b1;
      focus_motor_level    <= filt_ff.motor;
    end
  end
  assign focus_motor_oe = 1'b0;
  assign spare_gpio_out = `SPARE_GPIO_RST;
  assign spare_gpio_oe  = 16'hffff;

  // ---------------------------------------------------------------
  // control port i2c slave, write only
  // ---------------------------------------------------------------
  mirror_light_pkg::i2c_state_t i2c_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic       is_addr_ff, scl_d_ff, sda_d_ff, ack_ff;
  logic       scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = filt_ff.scl && !scl_d_ff;
  assign scl_fall = !filt_ff.scl && scl_d_ff;
  assign start_c  = filt_ff.scl && scl_d_ff && sda_d_ff && !filt_ff.sda;
  assign stop_c   = filt_ff.scl && scl_d_ff && !sda_d_ff && filt_ff.sda;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      i2c_ff     <= mirror_light_pkg::i2c_idle;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      is_addr_ff <= 1'b0;
      scl_d_ff   <= 1'b1;
      sda_d_ff   <= 1'b1;
      ack_ff     <= 1'b0;
      ctrl_cmd   <= '0;
    end else begin
      scl_d_ff       <= filt_ff.scl;
      sda_d_ff       <= filt_ff.sda;
      ctrl_cmd.valid <= 1'b0;
      if (start_c) begin
        i2c_ff     <= mirror_light_pkg::i2c_bits;
        bit_cnt_ff <= 4'h0;
        is_addr_ff <= 1'b1;
        ack_ff     <= 1'b0;
      end else if (stop_c) begin
        i2c_ff <= mirror_light_pkg::i2c_idle;
        ack_ff <= 1'b0;
      end else begin
        unique case (i2c_ff)
          mirror_light_pkg::i2c_idle: ;
          mirror_light_pkg::i2c_bits: begin
            if (scl_rise) begin
              shift_ff   <= {shift_ff[6:0], filt_ff.sda};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && bit_cnt_ff == 4'h8) begin
              // reads are not served: a read address is not acknowledged
              if (!is_addr_ff || shift_ff == {`CTRL_I2C_ADDR, 1'b0}) begin
                ack_ff <= 1'b1;
                i2c_ff <= mirror_light_pkg::i2c_ack;
                if (!is_addr_ff) ctrl_cmd <= '{1'b1, shift_ff};
              end else begin
                i2c_ff <= mirror_light_pkg::i2c_idle;
              end
            end
          end
          mirror_light_pkg::i2c_ack: if (scl_fall) begin
            ack_ff     <= 1'b0;
            is_addr_ff <= 1'b0;
            bit_cnt_ff <= 4'h0;
            i2c_ff     <= mirror_light_pkg::i2c_bits;
          end
          default: i2c_ff <= mirror_light_pkg::i2c_idle;
        endcase
      end
    end
  end
  assign control_port_clock_out = 1'b0;
  assign control_port_clock_oe  = 1'b0;
  assign control_port_data_out  = 1'b0;
  assign control_port_data_oe   = ack_ff;

  // ---------------------------------------------------------------
  // slow mirror serial link
  // ---------------------------------------------------------------
  logic [3:0] div_ff;
  logic [2:0] ls_cnt_ff;
  logic [7:0] wsh_ff;
  logic       tick;
  assign tick = (div_ff == `LS_DIV - 4'h1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) div_ff <= 4'h0;
    else div_ff <= (tick || !ls_busy) ? 4'h0 : div_ff + 4'h1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ls_busy                <= 1'b0;
      ls_cnt_ff              <= 3'h0;
      wsh_ff                 <= 8'h00;
      ls_rbyte               <= 8'h00;
      mirror_slow_serial_clk <= 1'b0;
      mirror_slow_write_line <= 1'b0;
    end else if (!ls_busy) begin
      if (ls_go) begin
        ls_busy                <= 1'b1;
        ls_cnt_ff              <= 3'h0;
        wsh_ff                 <= ls_wbyte;
        mirror_slow_write_line <= ls_wbyte[7];
      end
    end else if (tick) begin
      mirror_slow_serial_clk <= !mirror_slow_serial_clk;
      if (!mirror_slow_serial_clk) begin
        ls_rbyte <= {ls_rbyte[6:0], filt_ff.ls_read};
      end else begin
        ls_cnt_ff              <= ls_cnt_ff + 3'h1;
        wsh_ff                 <= {wsh_ff[6:0], 1'b0};
        mirror_slow_write_line <= wsh_ff[6];
        if (ls_cnt_ff == 3'h7) ls_busy <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // fast mirror lanes
  // ---------------------------------------------------------------
  function automatic logic [7:0] remap(input logic [7:0] d, input logic [23:0] m);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) r[i] = d[m[i*3 +: 3]];
    return r;
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mirror_fast_lanes   <= 8'h00;
      mirror_fast_clk_pos <= 1'b0;
    end else if (mirror_enable_reset_n) begin
      mirror_fast_lanes   <= remap(lane_data, lane_map);
      mirror_fast_clk_pos <= !mirror_fast_clk_pos;
    end else begin
      mirror_fast_lanes   <= 8'h00;
      mirror_fast_clk_pos <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // thermistor successive approximation
  // ---------------------------------------------------------------
  // charge time per trial is proportional to the trial code
  logic [7:0] win_ff, trial_ff;
  logic [2:0] sar_bit_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      therm_busy              <= 1'b0;
      win_ff                  <= 8'h00;
      trial_ff                <= 8'h00;
      sar_bit_ff              <= 3'h7;
      therm_result            <= 8'h00;
      thermistor_charge_drive <= 1'b0;
      thermistor_power        <= 1'b0;
    end else begin
      thermistor_power <= therm_enable && therm_busy;
      if (!therm_busy) begin
        thermistor_charge_drive <= 1'b0;
        if (therm_go && therm_enable) begin
          therm_busy <= 1'b1;
          win_ff     <= 8'h00;
          sar_bit_ff <= 3'h7;
          trial_ff   <= 8'h80;
        end
      end else if (!therm_enable) begin
        therm_busy              <= 1'b0;
        thermistor_charge_drive <= 1'b0;
      end else begin
        win_ff                  <= win_ff + 8'h01;
        thermistor_charge_drive <= (win_ff < trial_ff);
        if (win_ff == `SAR_WIN_LAST) begin
          // comparator high: rc level passed the thermistor, trial too big
          if (sar_bit_ff == 3'h0) begin
            therm_result <= filt_ff.cmp ? {trial_ff[7:1], 1'b0} : trial_ff;
            therm_busy   <= 1'b0;
          end else begin
            trial_ff   <= (filt_ff.cmp ? (trial_ff & ~(8'h01 << sar_bit_ff)) : trial_ff)
                          | (8'h01 << (sar_bit_ff - 3'h1));
            sar_bit_ff <= sar_bit_ff - 3'h1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_light_dark; state_ff != mirror_light_pkg::st_run |=> !light_select_bit0 && !light_select_bit1; endproperty
  a_light_dark: assert property (p_light_dark) else $error("light on outside run");
  property p_light_code;
    state_ff == mirror_light_pkg::st_run && filt_ff.park_n |=> {light_select_bit1, light_select_bit0} == $past(light_req);
  endproperty
  a_light_code: assert property (p_light_code) else $error("light code mismatch");
  property p_en_fall; $fell(mirror_enable_reset_n) |-> $past(state_ff) == mirror_light_pkg::st_parked; endproperty
  a_en_fall: assert property (p_en_fall) else $error("enable dropped before park");
  property p_notify; state_ff == mirror_light_pkg::st_init |=> host_notify_oe && host_notify_out == `NOTIFY_BUSY; endproperty
  a_notify: assert property (p_notify) else $error("notify not busy in init");
  property p_park_go;
    state_ff == mirror_light_pkg::st_run && !filt_ff.park_n |=> state_ff == mirror_light_pkg::st_parking;
  endproperty
  a_park_go: assert property (p_park_go) else $error("park request ignored");
  property p_park_hold;
    state_ff == mirror_light_pkg::st_parking && park_cnt_ff != 12'(PARK_LAST) |=> state_ff == mirror_light_pkg::st_parking;
  endproperty
  a_park_hold: assert property (p_park_hold) else $error("park cut short");
  property p_flash; flash_req && state_ff != mirror_light_pkg::st_reset |=> !flash_select_n; endproperty
  a_flash: assert property (p_flash) else $error("flash select not active");
  property p_cmd_pulse; ctrl_cmd.valid |=> !ctrl_cmd.valid; endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command valid too long");
  property p_ls_clk; mirror_slow_serial_clk |-> ls_busy; endproperty
  a_ls_clk: assert property (p_ls_clk) else $error("slow clock idle toggle");
  property p_charge; thermistor_charge_drive |-> $past(therm_busy); endproperty
  a_charge: assert property (p_charge) else $error("charge outside measurement");
  property p_tpower; therm_busy && therm_enable |=> thermistor_power; endproperty
  a_tpower: assert property (p_tpower) else $error("thermistor unpowered");
  property p_sync; $changed(filt_ff.park_n) |-> $past(s2_ff.park_n) == $past(s3_ff.park_n); endproperty
  a_sync: assert property (p_sync) else $error("park filter unstable");

  c_park:  cover property (state_ff == mirror_light_pkg::st_parked ##1 state_ff == mirror_light_pkg::st_run);
  c_cmd:   cover property (ctrl_cmd.valid);
  c_ls:    cover property ($fell(ls_busy));
  c_therm: cover property ($fell(therm_busy));
endmodule // mirror_light_control_pins

// >>> include/mirror_light_cfg.svh
`ifndef MIRROR_LIGHT_CFG_SVH
`define MIRROR_LIGHT_CFG_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_KHZ          20000
`define PARK_TIME_US     100
`define PARK_CYCLES      ((`PARK_TIME_US * `CLK_KHZ + 999) / 1000)
`define PARK_REQ_MIN_MS  200
`define LS_DIV           4'h4
`define SAR_WIN_LAST     8'hff
// ---------------------------------------------------------------
// addresses and reset values
// ---------------------------------------------------------------
`define CTRL_I2C_ADDR    7'h1b
`define NOTIFY_BUSY      1'b0
`define NOTIFY_DONE      1'b1
`define SPARE_GPIO_RST   16'h0000
`endif

// >>> include/mirror_light_pkg.sv
package mirror_light_pkg;
  typedef enum logic [1:0] {
    light_none  = 2'b00,
    light_red   = 2'b01,
    light_green = 2'b10,
    light_blue  = 2'b11
  } light_source_t;

  typedef enum logic [2:0] {
    st_reset   = 3'b000,
    st_init    = 3'b001,
    st_run     = 3'b010,
    st_parking = 3'b011,
    st_parked  = 3'b100
  } ctrl_state_t;

  typedef enum logic [1:0] {
    i2c_idle = 2'b00,
    i2c_bits = 2'b01,
    i2c_ack  = 2'b10
  } i2c_state_t;

  typedef struct packed {
    logic park_n;
    logic ls_read;
    logic cmp;
    logic motor;
    logic scl;
    logic sda;
  } pin_in_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ctrl_cmd_t;
endpackage

// >>> tb/mirror_board_model.sv
module mirror_board_model #(
  parameter logic [7:0] THRESH = 8'h5a
) (
  input  wire logic       clk,
  input  wire logic       scl_drv,
  input  wire logic       sda_drv,
  input  wire logic       scl_oe,
  input  wire logic       sda_oe,
  output logic            scl_w,
  output logic            sda_w,
  input  wire logic       n_out,
  input  wire logic       n_oe,
  output logic            notify_w,
  input  wire logic       charge,
  output logic            cmp,
  input  wire logic       slow_clk,
  input  wire logic       wline,
  output logic            rline,
  input  wire logic       load,
  input  wire logic [7:0] reply,
  output logic [7:0]      wr_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic       pc;
  // -----------------------------
  // board wires with pull-ups
  // -----------------------------
  assign scl_w = scl_drv & ~scl_oe;
  assign sda_w = sda_drv & ~sda_oe;
  assign notify_w = n_oe ? n_out : 1'b1;
  // -----------------------------
  // mirror slow link responder
  // -----------------------------
  // next bit leaves just after the sampling rise: a full period covers the pin filter
  always @(posedge slow_clk or posedge load) begin
    if (load) sh <= reply;
    else sh <= {sh[6:0], ~sh[7]};
  end
  assign rline = sh[7];
  always @(posedge slow_clk) wr_seen <= {wr_seen[6:0], wline};
  // -----------------------------
  // thermistor rc and comparator
  // -----------------------------
  always @(posedge clk) begin
    pc <= charge;
    if (charge) cnt <= pc ? cnt + 8'h01 : 8'h01;
  end
  assign cmp = cnt > THRESH;
endmodule // mirror_board_model

// >>> tb/mirror_light_control_pins_tb.sv
module mirror_light_control_pins_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, init_done, host_projection_on, flash_req, ls_go, therm_enable, therm_go;
  logic focus_motor_sense, scl_drv, sda_drv, control_port_clock_line, control_port_data_line, load;
  logic mirror_slow_read_line, comparator_result_in, notify_w;
  logic light_select_bit0, light_select_bit1, mirror_enable_reset_n, mirror_parked, host_notify_out;
  logic host_notify_oe, flash_select_n, spare_flash_select_n, control_port_clock_oe, control_port_data_oe;
  logic mirror_slow_serial_clk, mirror_slow_write_line, ls_busy, thermistor_charge_drive;
  logic thermistor_power, therm_busy, focus_motor_level, focus_motor_oe, mirror_fast_clk_pos, fclk;
  logic [7:0] ls_wbyte, ls_rbyte, lane_data, mirror_fast_lanes, therm_result, reply, wr_seen, got_cmd;
  logic [23:0] lane_map;
  logic [15:0] spare_gpio_out, spare_gpio_oe;
  mirror_light_pkg::light_source_t light_req;
  mirror_light_pkg::ctrl_cmd_t ctrl_cmd;
  int miscompares, n_checks, cycles;
  mirror_light_control_pins i_mirror_light_control_pins (.clk, .rst_b, .init_done, .light_req,
    .host_projection_on, .light_select_bit0, .light_select_bit1, .mirror_enable_reset_n, .mirror_parked,
    .host_notify_out, .host_notify_oe, .flash_req, .flash_select_n, .spare_flash_select_n,
    .control_port_clock_line, .control_port_data_line, .control_port_clock_out(), .control_port_clock_oe,
    .control_port_data_out(), .control_port_data_oe, .ctrl_cmd, .ls_go, .ls_wbyte, .mirror_slow_serial_clk,
    .mirror_slow_write_line, .mirror_slow_read_line, .ls_rbyte, .ls_busy, .lane_data, .lane_map,
    .mirror_fast_lanes, .mirror_fast_clk_pos, .therm_enable, .therm_go, .thermistor_charge_drive,
    .thermistor_power, .comparator_result_in, .therm_result, .therm_busy, .focus_motor_sense,
    .focus_motor_level, .focus_motor_oe, .spare_gpio_out, .spare_gpio_oe);
  mirror_board_model i_mirror_board_model (.clk, .scl_drv, .sda_drv, .scl_oe(control_port_clock_oe),
    .sda_oe(control_port_data_oe), .scl_w(control_port_clock_line), .sda_w(control_port_data_line),
    .n_out(host_notify_out), .n_oe(host_notify_oe), .notify_w, .charge(thermistor_charge_drive),
    .cmp(comparator_result_in), .slow_clk(mirror_slow_serial_clk), .wline(mirror_slow_write_line),
    .rline(mirror_slow_read_line), .load, .reply, .wr_seen);
  // -----------------------------
  // clock, timeout, helpers
  // -----------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (ctrl_cmd.valid) got_cmd <= ctrl_cmd.data;
    if (cycles == 10000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // scl held 10 cycles per phase, well above the input filter
  task automatic i2c_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      cyc(10);
      scl_drv = 1'b1;
      cyc(10);
      scl_drv = 1'b0;
    end
    sda_drv = 1'b1;
    cyc(10);
    chk("ack", control_port_data_line, 1'b0);
    scl_drv = 1'b1;
    cyc(10);
    scl_drv = 1'b0;
  endtask
  // -----------------------------
  // main sequence
  // -----------------------------
  initial begin
    {rst_b, init_done, flash_req, ls_go, therm_enable, therm_go, focus_motor_sense, load} = '0;
    {host_projection_on, scl_drv, sda_drv} = 3'b111;
    {ls_wbyte, lane_data, reply, lane_map} = '0;
    light_req = mirror_light_pkg::light_none;
    cyc(2);
    chk("lights_rst", {light_select_bit1, light_select_bit0}, 2'b00);
    chk("enable_rst", mirror_enable_reset_n, 1'b0);
    chk("notify_rst", {host_notify_oe, notify_w}, 2'b01);
    chk("flash_rst", {flash_select_n, spare_flash_select_n}, 2'b11);
    chk("fast_rst", {mirror_fast_clk_pos, mirror_fast_lanes}, 9'h000);
    rst_b = 1'b1;
    light_req = mirror_light_pkg::light_red;
    cyc(20);
    chk("lights_init", {light_select_bit1, light_select_bit0}, 2'b00);
    chk("notify_busy", {host_notify_oe, host_notify_out}, 2'b10);
    init_done = 1'b1;
    cyc(3);
    chk("notify_done", notify_w, 1'b1);
    chk("enable_run", mirror_enable_reset_n, 1'b1);
    for (int i = 0; i < 4; i++) begin
      light_req = mirror_light_pkg::light_source_t'(i);
      cyc(2);
      chk("lights", {light_select_bit1, light_select_bit0}, i);
    end
    lane_map = 24'h053977;
    lane_data = 8'h1e;
    flash_req = 1'b1;
    focus_motor_sense = 1'b1;
    cyc(6);
    chk("lanes", mirror_fast_lanes, 8'h78);
    chk("flash_sel", {flash_select_n, spare_flash_select_n}, 2'b01);
    chk("focus", {focus_motor_level, focus_motor_oe}, 2'b10);
    chk("spare_gpio", {spare_gpio_out, spare_gpio_oe}, 32'h0000ffff);
    fclk = mirror_fast_clk_pos;
    cyc(1);
    chk("fast_clk", mirror_fast_clk_pos, !fclk);
    flash_req = 1'b0;
    reply = 8'hc3;
    load = 1'b1;
    cyc(1);
    load = 1'b0;
    ls_wbyte = 8'h96;
    ls_go = 1'b1;
    cyc(1);
    ls_go = 1'b0;
    for (int i = 0; i < 100 && ls_busy; i++) cyc(1);
    cyc(2);
    chk("ls_read", {ls_busy, ls_rbyte}, 9'h0c3);
    chk("ls_write", wr_seen, 8'h96);
    therm_enable = 1'b1;
    therm_go = 1'b1;
    cyc(1);
    therm_go = 1'b0;
    cyc(3);
    chk("therm_pwr_on", thermistor_power, 1'b1);
    for (int i = 0; i < 2200 && therm_busy; i++) cyc(1);
    chk("therm_result", {therm_busy, therm_result}, 9'h05a);
    therm_enable = 1'b0;
    cyc(2);
    chk("therm_pwr_off", thermistor_power, 1'b0);
    sda_drv = 1'b0;
    cyc(10);
    scl_drv = 1'b0;
    i2c_byte(8'h36);
    i2c_byte(8'ha5);
    sda_drv = 1'b0;
    cyc(10);
    scl_drv = 1'b1;
    cyc(10);
    sda_drv = 1'b1;
    cyc(10);
    chk("ctrl_cmd", got_cmd, 8'ha5);
    chk("port_idle", {control_port_clock_oe, control_port_data_oe}, 2'b00);
    // park low held to the end; the 200 ms host minimum is far beyond this run
    host_projection_on = 1'b0;
    cyc(2);
    chk("lights_sync", {light_select_bit1, light_select_bit0}, 2'b11);
    cyc(8);
    chk("lights_park", {light_select_bit1, light_select_bit0}, 2'b00);
    cyc(1000);
    chk("enable_parking", mirror_enable_reset_n, 1'b1);
    cyc(1010);
    chk("parked", {mirror_enable_reset_n, mirror_parked}, 2'b01);
    final_report();
  end
endmodule // mirror_light_control_pins_tb
